// ### stio_ext_eq.sv
// Purpose: external gear on the trigger line
// Assumes: line pulled up when nobody drives it
// Notes:   lets go of the line while the block drives it
`timescale 1ns/1ps
module stio_ext_eq (
  input  wire logic clk_sys,
  input  wire logic inv,
  input  wire logic blockOe,
  output logic      drvEn,
  output logic      drvLvl
);
  logic busy = 1'b0;
  assign drvEn  = !blockOe;
  assign drvLvl = busy ? inv : !inv;
  // callers pass the minimum width or more, less only to test refusal
  task automatic pulse(input int n);
    busy <= 1'b1;
    repeat (n) @(posedge clk_sys);
    busy <= 1'b0;
  endtask
endmodule

// ### stio_params.svh
// Purpose: constants for the status and trigger pin block
// Assumes: 25 MHz system clock
// Notes:   offsets are byte addresses on the APB slave
`ifndef STIO_PARAMS_SVH
`define STIO_PARAMS_SVH

`define STIO_CLK_HZ         25000000
`define STIO_TRIG_MIN_NS    30000
// least width rounds up to whole cycles
`define STIO_TRIG_CYC       ((`STIO_TRIG_MIN_NS * 25 + 999) / 1000)

`define STIO_OFF_CTRL       12'h000
`define STIO_OFF_STAT       12'h004
`define STIO_OFF_CMD        12'h008

`define STIO_CTRL_STINV     0
`define STIO_CTRL_TRINV     1
`define STIO_CTRL_TRDIR     2
`define STIO_CTRL_TGT_LO    3
`define STIO_CTRL_TGT_HI    4
`define STIO_CTRL_LSRC      5
`define STIO_CTRL_RST       32'h0000_0000

`define STIO_STAT_OUTON     0
`define STIO_STAT_PIN       1
`define STIO_STAT_PULSE     2
`define STIO_STAT_CNT_LO    8
`define STIO_STAT_CNT_HI    15

`define STIO_CMD_FIRE       0

`endif

// ### stio_pins.sv
// Purpose: off-status pin and bidirectional trigger pin with APB registers
// Assumes: single 25 MHz clock, pins asynchronous to it
// Notes:   trigger pin is tri-state style: enable high while driving, both levels driven
//
// Functional notes
// - status pin high while output is off
// - status pin low while output is on
// - inversion flips status level both states
// - inversion applies to received and driven signals
// - trigger pin direction chosen by configuration
// - output pulse low for minimum width
// - input pulse starts the selected function
// - list starts only with external source
`timescale 1ns/1ps
`include "stio_params.svh"

module stio_pins
  import stio_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        outputOn,
  input  wire logic        intTrigger,
  output logic             statusPinOut,
  input  wire logic        trigPinIn,
  output logic             trigPinOut,
  output logic             trigPinOe,
  output logic             startMeter,
  output logic             startLog,
  output logic             startList
);

  localparam int unsigned TRIG_CYC = `STIO_TRIG_CYC;

  function automatic logic applyInv(input logic lvl, input logic inv);
    applyInv = lvl ^ inv;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register map, one word each:
  //   CTRL rw  bit0 status invert, bit1 trigger invert, bit2 direction
  //            out(1)/in(0), bits4:3 start target, bit5 list source ext
  //   STAT ro  bit0 output switch, bit1 synchronised pin, bit2 pulse
  //            active, bits15:8 accepted input triggers (wraps)
  //   CMD  wo  bit0 fires a trigger pulse; ignored in input direction
  // unmapped offsets answer with pslverr and read as zero; every
  // access completes with no wait state, so pready is tied high

  // one-hot register select, shared by the write and error paths
  function automatic logic [2:0] regSel(input logic [11:0] addr);
    logic [2:0] sel;
    sel = 3'h0;
    case (addr)
      `STIO_OFF_CTRL: sel = 3'h1;
      `STIO_OFF_STAT: sel = 3'h2;
      `STIO_OFF_CMD:  sel = 3'h4;
      default:        sel = 3'h0;
    endcase
    return sel;
  endfunction

  // start line picked by the target field; list also needs an
  // external source, a manual source leaves the pulse unused
  function automatic logic [2:0] startSel(input logic [1:0] tgt,
                                          input logic       listExt);
    logic [2:0] hot;
    hot = 3'h0;
    case (tgt)
      STIO_TGT_METER: hot = 3'h1;
      STIO_TGT_LOG:   hot = 3'h2;
      STIO_TGT_LIST:  hot = listExt ? 3'h4 : 3'h0;
      default:        hot = 3'h0;
    endcase
    return hot;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic        statusInv_q;
  logic        trigInv_q;
  logic        trigDirOut_q;
  logic [1:0]  target_q;
  logic        listSrcExt_q;
  logic        swFire;
  logic        rxSync1_q;
  logic        rxSync2_q;
  logic        txActive_q;
  logic [10:0] txCnt_q;
  logic [10:0] rxCnt_q;
  logic [7:0]  acceptCnt_q;
  logic        rxFire;
  stio_rx_e    rxState_q;

  logic [2:0]  regHit;
  logic        access;
  logic        wrCtrl;
  logic        mapped;
  logic [2:0]  startHot;

  assign access  = psel && penable;
  assign regHit  = regSel(paddr);
  assign wrCtrl  = access && pwrite && regHit[0];
  assign mapped  = |regHit;

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  // a write to CMD is a strobe: nothing of it is stored
  assign swFire  = access && pwrite && regHit[2] &&
                   pwdata[`STIO_CMD_FIRE];

  // status inversion acts on the driven status pin, trigger inversion on the trigger pin in both directions
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      statusInv_q <= 1'b0;
      trigInv_q   <= 1'b0;
    end else if (wrCtrl) begin
      statusInv_q <= pwdata[`STIO_CTRL_STINV];
      trigInv_q   <= pwdata[`STIO_CTRL_TRINV];
    end
  end

  // direction of the trigger pin
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      trigDirOut_q <= 1'b0;
    end else if (wrCtrl) begin
      trigDirOut_q <= pwdata[`STIO_CTRL_TRDIR];
    end
  end

  // start target and list trigger source
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      target_q     <= 2'h0;
      listSrcExt_q <= 1'b0;
    end else if (wrCtrl) begin
      target_q     <= pwdata[`STIO_CTRL_TGT_HI:`STIO_CTRL_TGT_LO];
      listSrcExt_q <= pwdata[`STIO_CTRL_LSRC];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        `STIO_OFF_CTRL: begin
          prdata[`STIO_CTRL_STINV] <= statusInv_q;
          prdata[`STIO_CTRL_TRINV] <= trigInv_q;
          prdata[`STIO_CTRL_TRDIR] <= trigDirOut_q;
          prdata[`STIO_CTRL_TGT_HI:`STIO_CTRL_TGT_LO] <= target_q;
          prdata[`STIO_CTRL_LSRC]  <= listSrcExt_q;
        end
        `STIO_OFF_STAT: begin
          prdata[`STIO_STAT_OUTON] <= outputOn;
          prdata[`STIO_STAT_PIN]   <= rxSync2_q;
          prdata[`STIO_STAT_PULSE] <= txActive_q;
          prdata[`STIO_STAT_CNT_HI:`STIO_STAT_CNT_LO] <= acceptCnt_q;
        end
        default: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status pin: off reads high, on reads low, inversion flips both
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      statusPinOut <= 1'b1;
    end else begin
      statusPinOut <= applyInv(!outputOn,
                          statusInv_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger output: low-going pulse; a retrigger during it restarts width
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      txActive_q <= 1'b0;
      txCnt_q    <= 11'h000;
    end else if (trigDirOut_q && (intTrigger || swFire)) begin
      txActive_q <= 1'b1;
      txCnt_q    <= 11'(TRIG_CYC - 1);
    end else if (txActive_q) begin
      // ends at zero: exactly the minimum width low, no cycle short
      if (txCnt_q == 11'h000) begin
        txActive_q <= 1'b0;
      end else begin
        txCnt_q <= txCnt_q - 11'h001;
      end
    end
  end

  // pin idles high and an asserted pulse is low; inversion swaps both levels on request
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      trigPinOut <= 1'b1;
      trigPinOe  <= 1'b0;
    end else begin
      trigPinOut <= applyInv(!txActive_q, trigInv_q);
      trigPinOe  <= trigDirOut_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rxSync1_q <= 1'b1;
      rxSync2_q <= 1'b1;
    end else begin
      // only the second stage is read; the first may still be settling
      rxSync1_q <= trigPinIn;
      rxSync2_q <= rxSync1_q;
    end
  end

  // asserted level is low unless inverted
  wire rxAsserted = !applyInv(rxSync2_q, trigInv_q);

  // accept once the level has held for the minimum width, then wait for
  // release so one long pulse fires one start only
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rxState_q <= STIO_IDLE;
      rxCnt_q   <= 11'h000;
    end else begin
      case (rxState_q)
        STIO_IDLE: begin
          rxCnt_q <= 11'h000;
          if (!trigDirOut_q && rxAsserted) begin
            rxState_q <= STIO_LOW;
          end
        end
        STIO_LOW: begin
          if (!rxAsserted || trigDirOut_q) begin
            rxState_q <= STIO_IDLE;
          end else if (rxCnt_q == 11'(TRIG_CYC - 2)) begin
            rxState_q <= STIO_WAITH;
          end else begin
            rxCnt_q <= rxCnt_q + 11'h001;
          end
        end
        STIO_WAITH: begin
          if (!rxAsserted) begin
            rxState_q <= STIO_IDLE;
          end
        end
        default: begin
          rxState_q <= STIO_IDLE;
        end
      endcase
    end
  end

  // fires in the last counting cycle; the state moves on at that edge
  assign rxFire = (rxState_q == STIO_LOW) && rxAsserted && !trigDirOut_q &&
                  (rxCnt_q == 11'(TRIG_CYC - 2));

  // rxFire lasts one cycle, so each start strobe is one cycle wide
  assign startHot = rxFire ? startSel(target_q, listSrcExt_q) : 3'h0;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      startMeter <= 1'b0;
      startLog   <= 1'b0;
      startList  <= 1'b0;
    end else begin
      startMeter <= startHot[0];
      startLog   <= startHot[1];
      startList  <= startHot[2];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      acceptCnt_q <= 8'h00;
    end else if (rxFire) begin
      // counts every accepted pulse, whatever the target; wraps at 255
      acceptCnt_q <= acceptCnt_q + 8'h01;
    end
  end

endmodule

// ### stio_pins_assertions.sv
// Purpose: port checks for the status and trigger pins
// Assumes: pin setup mirrored from APB writes to CTRL
// Notes:   bound into stio_pins
`timescale 1ns/1ps
`include "stio_params.svh"
module stio_pins_chk
  import stio_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        outputOn,
  input wire logic        intTrigger,
  input wire logic        statusPinOut,
  input wire logic        trigPinIn,
  input wire logic        trigPinOut,
  input wire logic        trigPinOe,
  input wire logic        startMeter,
  input wire logic        startLog,
  input wire logic        startList
);
  logic [31:0] ctl_q;
  logic [11:0] actCnt_q;
  logic [11:0] inRun_q;
  logic        inAct_q;
  wire         inAct  = trigPinIn == ctl_q[1];
  wire  [2:0]  starts = {startList, startLog, startMeter};
  wire  [2:0]  pick   = ctl_q[4:3] == 2'h0 ? 3'h1 : ctl_q[4:3] == 2'h1 ? 3'h2
                      : (ctl_q[4:3] == 2'h2 && ctl_q[5]) ? 3'h4 : 3'h0;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b) ctl_q <= 32'h0;
    else if (psel && penable && pwrite && paddr == `STIO_OFF_CTRL)
      ctl_q <= pwdata;
  // length of the current asserted run on the driven pin
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b) actCnt_q <= 12'h0;
    else actCnt_q <= trigPinOut == ctl_q[1] ? actCnt_q + 12'h1 : 12'h0;
  // length of the last asserted run seen at the pin, kept after release
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b) inAct_q <= 1'b0;
    else inAct_q <= inAct;
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b) inRun_q <= 12'h0;
    else if (inAct) inRun_q <= inAct_q ? inRun_q + 12'h1 : 12'h1;
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_fire; intTrigger && ctl_q[2]; endsequence
  sequence s_drive; ##2 trigPinOut == ctl_q[1]; endsequence
  a_stat_level: assert property ($past(rst_b) |->
    statusPinOut == (!$past(outputOn) ^ $past(ctl_q[0]))) else $error("stat");
  a_oe_follow: assert property (trigPinOe != ctl_q[2] |=>
    trigPinOe == ctl_q[2]) else $error("enable");
  a_trig_launch: assert property (s_fire |-> s_drive)
    else $error("no pulse");
  a_pulse_width: assert property (trigPinOe && $past(trigPinOe) &&
    trigPinOut != ctl_q[1] && $past(trigPinOut) == ctl_q[1]
    |-> actCnt_q >= `STIO_TRIG_CYC) else $error("short pulse");
  a_no_start_out: assert property (trigPinOe |-> starts == 3'h0)
    else $error("start in output mode");
  a_start_pick: assert property (starts != 3'h0 |->
    starts == pick) else $error("wrong start");
  a_start_accept: assert property (starts != 3'h0 |->
    inRun_q >= `STIO_TRIG_CYC) else $error("early start");
  a_start_single: assert property (starts != 3'h0 |=>
    (starts == 3'h0) [*8]) else $error("repeated start");
endmodule
bind stio_pins stio_pins_chk u_stio_pins_chk (.clk_sys, .rst_b, .psel,
  .penable, .pwrite, .paddr, .pwdata, .outputOn, .intTrigger,
  .statusPinOut, .trigPinIn, .trigPinOut, .trigPinOe, .startMeter,
  .startLog, .startList);

// ### stio_pkg.sv
// Purpose: types for the status and trigger pin block
// Assumes: nothing
// Notes:   none
package stio_pkg;
  typedef enum logic [1:0] {
    STIO_TGT_METER = 2'h0,
    STIO_TGT_LOG   = 2'h1,
    STIO_TGT_LIST  = 2'h2,
    STIO_TGT_NONE  = 2'h3
  } stio_tgt_e;

  typedef enum logic [2:0] {
    STIO_IDLE  = 3'h1,
    STIO_LOW   = 3'h2,
    STIO_WAITH = 3'h4
  } stio_rx_e;
endpackage

// ### tb.sv
// Purpose: self-checking bench for the status and trigger pins
// Assumes: 25 MHz clock, trigger line pulled up
// Notes:   xorshift values seeded at 49
`timescale 1ns/1ps
`include "stio_params.svh"
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin nFail++; \
  $display("[ERR] %0t got %h want %h", $time, g, e); end end
module tb
  import stio_pkg::*;
;
  logic        clk_sys, rst_b, psel, penable, pwrite, outputOn, intTrigger;
  logic        pready, pslverr, statusPinOut, trigPinOut, trigPinOe, err;
  logic        startMeter, startLog, startList, drvEn, drvLvl, extInv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r, seed = 32'h0000_0031;
  logic [2:0]  expQ[$];
  logic [10:0] cfg[5] = '{11'h100, 11'h20A, 11'h010, 11'h430, 11'h018};
  int          nFail = 0, nTests = 0, cyc = 0;
  wire         trigLine = trigPinOe ? trigPinOut : drvEn ? drvLvl : 1'b1;
  wire  [2:0]  starts = {startList, startLog, startMeter};
  stio_pins u_stio_pins (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .outputOn, .intTrigger,
    .statusPinOut, .trigPinIn(trigLine), .trigPinOut, .trigPinOe,
    .startMeter, .startLog, .startList);
  stio_ext_eq u_stio_ext_eq (.clk_sys, .inv(extInv), .blockOe(trigPinOe),
    .drvEn, .drvLvl);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // one idle cycle after each transfer keeps drives one per time step
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic closeOut();
    $display("tests %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      nFail++;
      closeOut();
    end
  end
  always @(posedge clk_sys)
    if (starts !== 3'h0)
      `CHK(starts, expQ.size() > 0 ? expQ.pop_front() : 3'h0)
  initial begin
    {rst_b, psel, penable, pwrite, outputOn, intTrigger, extInv} = 7'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 12; i++) begin
      if (i == 6) apb(1'b1, `STIO_OFF_CTRL, 32'h1);
      r = rnd();
      outputOn <= r[0];
      repeat (2) @(posedge clk_sys);
      `CHK(statusPinOut, !r[0] ^ (i >= 6))
    end
    apb(1'b0, `STIO_OFF_CTRL, rnd());
    `CHK(rd, 32'h1)
    `CHK(err, 1'b0)
    apb(1'b0, 12'h00C, rnd());
    `CHK(rd, 32'h0)
    `CHK(err, 1'b1)
    $display("test status done");
    foreach (cfg[k]) begin
      apb(1'b1, `STIO_OFF_CTRL, {24'h0, cfg[k][7:0]});
      extInv <= cfg[k][1];
      if (cfg[k][10:8] != 3'h0) expQ.push_back(cfg[k][10:8]);
      u_stio_ext_eq.pulse(750 + rnd() % 8);
      repeat (20) @(posedge clk_sys);
      if (k == 0) u_stio_ext_eq.pulse(740);
      repeat (20) @(posedge clk_sys);
    end
    `CHK(expQ.size(), 0)
    `CHK(trigPinOe, 1'b0)
    apb(1'b0, `STIO_OFF_STAT, rnd());
    `CHK(rd[15:1], 15'h0281)
    $display("test input done");
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `STIO_OFF_CTRL, k << 1);
      extInv <= k[0];
      apb(1'b1, `STIO_OFF_CTRL, (k << 1) | 4);
      for (int j = 0; j < 2; j++) begin
        if (j == 0) begin
          intTrigger <= 1'b1;
          @(posedge clk_sys);
          intTrigger <= 1'b0;
          repeat (3) @(posedge clk_sys);
        end else begin
          apb(1'b1, `STIO_OFF_CMD, 32'h1);
          repeat (2) @(posedge clk_sys);
        end
        `CHK(trigPinOut, k[0])
        `CHK(trigPinOe, 1'b1)
        repeat (747) @(posedge clk_sys);
        `CHK(trigPinOut, k[0])
        repeat (10) @(posedge clk_sys);
        `CHK(trigPinOut, !k[0])
      end
    end
    $display("test output done");
    closeOut();
  end
endmodule
